// [src/cmpc_consts.svh]
// Constants of the chip mode and power control block
// Included by the top module and the bench
`ifndef CMPC_CONSTS_SVH
`define CMPC_CONSTS_SVH
`define CMPC_ADDR_W     8
`define CMPC_OFF_MODE   8'h00
`define CMPC_OFF_CTRL   8'h04
`define CMPC_OFF_STAT   8'h08
`define CMPC_CTRL_BDCEN 0
`define CMPC_CTRL_CIS   1
`define CMPC_CTRL_FRZ   2
`define CMPC_CTRL_PSTOP 3
`define CMPC_CTRL_W     4
`define CMPC_CTRL_RST   4'h0
`define CMPC_MODE_RST   1'b1
`define CMPC_WAKE_CYC   2
`endif

// [src/cmpc_pkg.sv]
// Types of the chip mode and power control block
// Constants live in the consts header
package cmpc_pkg;
  typedef enum logic [2:0]
  {
    PS_RUN,
    PS_WAIT,
    PS_PSTOP,
    PS_STOP,
    PS_WAKE
  } cmpc_pstate_t;
endpackage

// [src/cmpc_top.sv]
// Chip mode, low power state and clock gating control
// AHB-Lite slave on core_clk; pins synchronised here;
// clock gates are enables for an external gating cell.
`timescale 1ns/1ns
`include "cmpc_consts.svh"
module cmpc_top
(
  input  wire logic        core_clk,      // 20 MHz clock
  input  wire logic        sys_rst,       // Sync reset, high
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write
  input  wire logic [2:0]  hsize,         // Size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response
  output logic [31:0]      hrdata,        // Read data
  input  wire logic        modeSelectPin, // Mode strap pin
  input  wire logic        nmiPin,        // Nonmaskable pin
  input  wire logic        irqPin,        // Interrupt pin
  input  wire logic        keyWakePin,    // Key wakeup pins
  input  wire logic        serialWake,    // Serial wake event
  input  wire logic        apiWake,       // Periodic wakeup
  input  wire logic        tickWake,      // Tick or watchdog
  input  wire logic        intPend,       // Locally unmasked
  input  wire logic        ccrI,          // Global mask bit
  input  wire logic        ccrU,          // CONDITION_CODE_REGISTER U bit
  input  wire logic        ccrS,          // CONDITION_CODE_REGISTER stop disable
  input  wire logic        waitInstr,     // Wait executed
  input  wire logic        stopInstr,     // Stop executed
  input  wire logic        nvmBusy,       // NVM command active
  input  wire logic        secured,       // Security state
  input  wire logic        bdcGo,         // Leave debug state
  input  wire logic        bdcBgnd,       // Enter debug state
  input  wire logic        bdcErase,      // Erase command
  output logic             cpuClkEn,      // CPU clock gate
  output logic             coreClkEn,     // Core clock gate
  output logic             busClkEn,      // Bus clock gate
  output logic             oscEn,         // Oscillator on
  output logic             ircClkEn,      // Reference clock
  output logic             apiClkEn,      // Wakeup clock
  output logic             bdcSerClkEn,   // Debug serial clk
  output logic             periphEn,      // Peripherals on
  output logic             tickEn,        // Tick, watchdog on
  output logic             cntFreeze,     // Counters frozen
  output logic             regFullPerf,   // Regulator full
  output logic             voltMonEn,     // Voltage monitor
  output logic             coreTimClkEn,  // Core timer, pwm
  output logic             busTimClkEn,   // Bus timer, pwm
  output logic             dbgProtoClkEn, // Debug proto clk
  output logic             dbgFastClkEn,  // Debug fast clk
  output logic             bgdActive,     // Debug state
  output logic             freezeReq,     // Module freeze
  output logic             eraseAllReq,   // Flash mass erase
  output logic             extMemBlock,   // Ext access blocked
  output logic             nvmRestrict,   // NVM restricted
  output logic             bdcMemEn,      // Debug mem access
  output cmpc_pkg::cmpc_pstate_t pState   // Power state
);
  import cmpc_pkg::*;

  //////////////////////////////////////////////////////////////
  // Pin synchronisers, first stage read by second only
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  logic       modeSync;
  logic       nmiSync;
  logic       irqSync;
  logic       keySync;

  always_ff @(posedge core_clk)
  begin
    pinMeta_r <= {keyWakePin, irqPin, nmiPin, modeSelectPin};
    pinSync_r <= pinMeta_r;
  end

  assign modeSync = pinSync_r[0];
  assign nmiSync  = pinSync_r[1];
  assign irqSync  = pinSync_r[2];
  assign keySync  = pinSync_r[3];

  //////////////////////////////////////////////////////////////
  // Bus slave, zero wait states
  logic                     wrPend_r;
  logic                     rdPend_r;
  logic [`CMPC_ADDR_W-1:0]  aAddr_r;
  logic                     addrOk;
  logic                     takeXfer;
  logic                     modeWr;
  logic                     ctrlWr;

  assign takeXfer  = hsel && htrans[1] && hready;
  assign addrOk    = (haddr[31:`CMPC_ADDR_W] == '0);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      aAddr_r  <= '0;
    end
    else
    begin
      wrPend_r <= takeXfer && hwrite && addrOk;
      rdPend_r <= takeXfer && !hwrite && addrOk;
      aAddr_r  <= haddr[`CMPC_ADDR_W-1:0];
    end
  end

  assign modeWr = wrPend_r && (aAddr_r == `CMPC_OFF_MODE);
  assign ctrlWr = wrPend_r && (aAddr_r == `CMPC_OFF_CTRL);

  //////////////////////////////////////////////////////////////
  // Mode bit and strap capture
  logic                   mode_r;
  logic                   rstDly_r;
  logic [`CMPC_CTRL_W-1:0] ctrl_r;
  logic                   rstRelease;
  logic                   bdcEn;
  logic                   cisBit;

  always_ff @(posedge core_clk)
    rstDly_r <= sys_rst;

  assign rstRelease = rstDly_r && !sys_rst;

  // Captured at release; special to normal only
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mode_r <= `CMPC_MODE_RST;
    else if (rstRelease)
      mode_r <= modeSync;
    else if (modeWr && hwdata[0])
      mode_r <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ctrl_r <= `CMPC_CTRL_RST;
    else if (ctrlWr)
      ctrl_r <= hwdata[`CMPC_CTRL_W-1:0];
  end

  assign bdcEn  = ctrl_r[`CMPC_CTRL_BDCEN] && !(secured && mode_r);
  assign cisBit = ctrl_r[`CMPC_CTRL_CIS];

  //////////////////////////////////////////////////////////////
  // Debug state
  logic bgd_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      bgd_r <= 1'b0;
    else if (rstRelease)
      bgd_r <= !modeSync;
    else if (bdcBgnd && bdcEn)
      bgd_r <= 1'b1;
    else if (bdcGo)
      bgd_r <= 1'b0;
  end

  assign bgdActive = bgd_r;
  assign freezeReq = bgd_r && ctrl_r[`CMPC_CTRL_FRZ];

  //////////////////////////////////////////////////////////////
  // Power state machine
  cmpc_pstate_t pState_r;
  cmpc_pstate_t pState_nxt;
  logic         stopPend_r;
  logic [1:0]   wakeCnt_r;
  logic         waitWake;
  logic         stopWake;
  logic         stopOk;

  assign waitWake = nmiSync || !irqSync || (intPend && !ccrI);
  assign stopWake = nmiSync || !irqSync || keySync
                 || serialWake || apiWake;
  // Stop is a no-op unless U, S clear
  assign stopOk = stopInstr && !ccrU && !ccrS;

  // Hold the request while nvm busy
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      stopPend_r <= 1'b0;
    else if (stopPend_r && !nvmBusy)
      stopPend_r <= 1'b0;
    else if (stopOk && pState_r == PS_RUN)
      stopPend_r <= 1'b1;
  end

  always_comb
  begin
    pState_nxt = pState_r;
    case (pState_r)
      PS_RUN:
        if (stopPend_r && !nvmBusy)
          pState_nxt = ctrl_r[`CMPC_CTRL_PSTOP] ? PS_PSTOP
                                                 : PS_STOP;
        else if (waitInstr && !stopPend_r)
          pState_nxt = PS_WAIT;
      PS_WAIT:
        if (waitWake)
          pState_nxt = PS_RUN;
      PS_PSTOP:
        if (stopWake || tickWake)
          pState_nxt = PS_WAKE;
      PS_STOP:
        if (stopWake)
          pState_nxt = PS_WAKE;
      PS_WAKE:
        if (wakeCnt_r == 2'(`CMPC_WAKE_CYC - 1))
          pState_nxt = PS_RUN;
      default:
        pState_nxt = PS_RUN;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      pState_r <= PS_RUN;
    else
      pState_r <= pState_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || pState_r != PS_WAKE)
      wakeCnt_r <= '0;
    else
      wakeCnt_r <= wakeCnt_r + 2'd1;
  end

  assign pState = pState_r;

  //////////////////////////////////////////////////////////////
  // Clock and regulator control
  logic inStop;
  logic inPstop;
  logic allOn;

  assign inStop  = (pState_r == PS_STOP);
  assign inPstop = (pState_r == PS_PSTOP);
  assign allOn   = inStop && bdcEn && cisBit;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cpuClkEn    <= 1'b1;
      coreClkEn   <= 1'b1;
      busClkEn    <= 1'b1;
      oscEn       <= 1'b1;
      ircClkEn    <= 1'b1;
      apiClkEn    <= 1'b1;
      bdcSerClkEn <= 1'b1;
      periphEn    <= 1'b1;
      tickEn      <= 1'b1;
      cntFreeze   <= 1'b0;
      regFullPerf <= 1'b1;
      voltMonEn   <= 1'b1;
    end
    else
    begin
      // Wait gates only the cpu clock
      cpuClkEn    <= pState_r == PS_RUN;
      coreClkEn   <= !(inStop || inPstop) || allOn;
      busClkEn    <= !(inStop || inPstop) || allOn;
      oscEn       <= !inStop || allOn;
      ircClkEn    <= !inStop || allOn || bdcEn;
      apiClkEn    <= 1'b1;
      // Serial debug clock stays in stop only while debug is enabled
      bdcSerClkEn <= !inStop || bdcEn;
      periphEn    <= !(inStop || inPstop) || allOn;
      tickEn      <= !inStop || allOn;
      cntFreeze   <= inStop && !allOn;
      regFullPerf <= !inStop || bdcEn;
      voltMonEn   <= !inStop || bdcEn;
    end
  end

  // Fast instances on core, others on bus
  assign coreTimClkEn  = coreClkEn;
  assign busTimClkEn   = busClkEn;
  // Protocol from reference, fast from bus
  assign dbgProtoClkEn = ircClkEn;
  assign dbgFastClkEn  = busClkEn;

  //////////////////////////////////////////////////////////////
  // Erase path and security
  // Erase command drives flash only while debug is enabled
  assign eraseAllReq = bdcErase && bdcEn;
  assign extMemBlock = secured;
  assign nvmRestrict = secured;
  assign bdcMemEn    = bdcEn && !secured;

  //////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      hrdata <= 32'h0;
    else if (takeXfer && !hwrite && addrOk)
    begin
      hrdata <= 32'h0;
      case (haddr[`CMPC_ADDR_W-1:0])
        `CMPC_OFF_MODE: hrdata[0] <= mode_r;
        `CMPC_OFF_CTRL: hrdata[`CMPC_CTRL_W-1:0] <= ctrl_r;
        `CMPC_OFF_STAT:
          hrdata[6:0] <= {secured, stopPend_r, bgd_r,
                          1'b0, 3'(pState_r)};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_stopReq;
    stopOk && pState_r == PS_RUN;
  endsequence

  sequence s_nvmFree;
    !nvmBusy;
  endsequence

  a_mode_capture: assert property (
    rstRelease |=> mode_r == $past(modeSync))
    else $error("mode not captured at release");

  a_special_debug: assert property (
    rstRelease && !modeSync |=> bgd_r)
    else $error("special mode did not enter debug");

  a_mode_limited: assert property (
    !rstRelease && !$past(rstRelease) |->
      !($fell(mode_r)))
    else $error("mode fell by software");

  a_stop_nvm: assert property (
    nvmBusy && pState_r == PS_RUN |=>
      pState_r inside {PS_RUN, PS_WAIT})
    else $error("stop entered with nvm busy");

  a_stop_enter: assert property (
    s_stopReq ##1 s_nvmFree [*2] |=>
      pState_r inside {PS_STOP, PS_PSTOP})
    else $error("stop not acknowledged");

  a_stop_nop: assert property (
    stopInstr && (ccrU || ccrS) && !stopPend_r |=>
      !stopPend_r)
    else $error("stop not ignored");

  a_wait_cpu: assert property (
    pState_r == PS_WAIT |=> !cpuClkEn && busClkEn)
    else $error("wait clock gating wrong");

  a_wait_exit: assert property (
    pState_r == PS_WAIT && waitWake |=> pState_r == PS_RUN)
    else $error("wait did not end");

  a_stop_regul: assert property (
    inStop && bdcEn |=> regFullPerf && voltMonEn)
    else $error("regulator reduced with debug");

  a_stop_clocks: assert property (
    inStop && !bdcEn |=> !oscEn && !busClkEn
                         && cntFreeze && !regFullPerf)
    else $error("full stop clocks wrong");

  a_pstop_osc: assert property (
    inPstop |=> oscEn && !busClkEn && tickEn)
    else $error("pseudo-stop clocks wrong");

  a_wake_run: assert property (
    pState_r == PS_STOP && stopWake |=>
      pState_r == PS_WAKE ##2 pState_r == PS_RUN)
    else $error("wake sequence wrong");

  a_erase_path: assert property (
    bdcErase && bdcEn |-> eraseAllReq)
    else $error("erase not forwarded");
endmodule

// [bench/cmpc_dbg_host.sv]
// Behavioural debug host on the background debug command lines
// Assumes the bench holds reqVal and reqCmd until done is seen
`timescale 1ns/1ns
module cmpc_dbg_host
(
  input  wire logic       clk,      // Core clock
  input  wire logic       reqVal,   // Command wanted
  input  wire logic [1:0] reqCmd,   // 1 go, 2 halt, 3 erase
  input  wire logic [3:0] lat,      // Cycles before acting
  output logic            bdcGo,    // Leave debug state
  output logic            bdcBgnd,  // Enter debug state
  output logic            bdcErase, // Mass erase command
  output logic            done      // Command finished
);
  ////////////////////////////////////////////////////////////////////////
  // commands only, never control writes
  initial
  begin
    {bdcGo, bdcBgnd, bdcErase, done} = 4'h0;
    forever
    begin
      @(posedge clk iff reqVal);
      repeat (lat) @(posedge clk);
      bdcGo <= reqCmd == 2'h1;
      bdcBgnd <= reqCmd == 2'h2;
      bdcErase <= reqCmd == 2'h3;
      // Erase held longer, so a slow flash still sees it
      repeat (reqCmd == 2'h3 ? 3 : 1) @(posedge clk);
      {bdcGo, bdcBgnd, bdcErase} <= 3'h0;
      done <= 1'h1;
      @(posedge clk);
      done <= 1'h0;
    end
  end
endmodule

// [bench/cmpc_top_tb.sv]
// Self-checking bench for the chip mode and power control block
// Assumes one bus slave and the behavioural debug host model
`timescale 1ns/1ns
`include "cmpc_consts.svh"
module cmpc_top_tb;
  import cmpc_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m;} cmpc_note_t;
  logic        core_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0;
  logic        hwrite = 1'h0, modeSelectPin = 1'h0, nmiPin = 1'h0;
  logic        irqPin = 1'h1, keyWakePin = 1'h0, serialWake = 1'h0;
  logic        apiWake = 1'h0, tickWake = 1'h0, intPend = 1'h0;
  logic        ccrI = 1'h1, ccrU = 1'h0, ccrS = 1'h0, waitInstr = 1'h0;
  logic        stopInstr = 1'h0, nvmBusy = 1'h0, secured = 1'h0;
  logic        lookNow = 1'h0, rdPh = 1'h0, reqVal = 1'h0, done;
  logic        hready, hreadyout, hresp, bdcGo, bdcBgnd, bdcErase;
  logic        cpuClkEn, coreClkEn, busClkEn, oscEn, ircClkEn, apiClkEn;
  logic        bdcSerClkEn, periphEn, tickEn, cntFreeze, regFullPerf;
  logic        voltMonEn, coreTimClkEn, busTimClkEn, dbgProtoClkEn;
  logic        dbgFastClkEn, bgdActive, freezeReq, eraseAllReq;
  logic        extMemBlock, nvmRestrict, bdcMemEn;
  logic [1:0]  htrans = 2'h0, reqCmd = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  lat = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, obs;
  logic [31:0] cV[4] = '{32'h0, 32'h8, 32'h1, 32'h3};
  logic [31:0] sE[4] = '{32'h00300080, 32'h00201100, 32'h00300C60,
                         32'h003D7C60};
  logic [31:0] sM[4] = '{32'h007DF2C0, 32'h007DF300, 32'h007DEC60,
                         32'h007D7C60};
  int          wSrc[3] = '{0, 1, 6};
  int          sSrc[4] = '{2, 5, 3, 4};
  int          n_errors = 0, n_compared = 0;
  cmpc_pstate_t pState;
  cmpc_note_t  noteQ[$];
  cmpc_note_t  note;

  assign hready = hreadyout;
  assign obs = {7'h0, hresp, bdcMemEn, pState, coreTimClkEn, busTimClkEn,
    dbgProtoClkEn, dbgFastClkEn, cpuClkEn, coreClkEn, busClkEn, oscEn,
    apiClkEn, bdcSerClkEn, periphEn, tickEn, cntFreeze, regFullPerf,
    voltMonEn, bgdActive, freezeReq, eraseAllReq, extMemBlock, nvmRestrict};

  cmpc_top dut_u (.*);
  cmpc_dbg_host host_u (.clk(core_clk), .reqVal, .reqCmd, .lat, .bdcGo,
    .bdcBgnd, .bdcErase, .done);

  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic look(input logic [31:0] e, input logic [31:0] m);
    noteQ.push_back('{e, m});
    lookNow <= 1'h1;
    @(posedge core_clk);
    lookNow <= 1'h0;
    @(posedge core_clk);
  endtask

  // Single word transfer; read data is judged by the monitor
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [31:0] m);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w)
      noteQ.push_back('{d, m});
    do @(posedge core_clk); while (hready !== 1'h1);
  endtask

  task automatic doReset(input logic strap);
    sys_rst <= 1'h1;
    modeSelectPin <= strap;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic pulse(input logic stop);
    if (stop)
      stopInstr <= 1'h1;
    else
      waitInstr <= 1'h1;
    @(posedge core_clk);
    stopInstr <= 1'h0;
    waitInstr <= 1'h0;
  endtask

  task automatic waitSt(input cmpc_pstate_t s);
    int i;
    for (i = 0; i < 40 && pState !== s; i++)
      @(posedge core_clk);
    check({29'h0, pState}, {29'h0, s});
  endtask

  task automatic setWake(input int k, input logic v);
    case (k)
      0: nmiPin <= v;
      1: irqPin <= !v;
      2: keyWakePin <= v;
      3: serialWake <= v;
      4: apiWake <= v;
      5: tickWake <= v;
      default: ccrI <= !v;
    endcase
  endtask

  task automatic dbg(input logic [1:0] c);
    reqVal <= 1'h1;
    reqCmd <= c;
    lat <= 4'($urandom_range(3));
    do @(posedge core_clk); while (bdcErase !== 1'h1 && done !== 1'h1);
    if (c == 2'h3)
      look(32'h4, 32'h4);
    while (done !== 1'h1)
      @(posedge core_clk);
    reqVal <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    if (rdPh || lookNow)
    begin
      note = noteQ.pop_front();
      check((rdPh ? hrdata : obs) & note.m, note.e & note.m);
    end
    rdPh <= !sys_rst && hsel && htrans[1] && hready && !hwrite;
  end

  // Far above the expected run length of some two hundred and fifty cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end

  initial
  begin
    void'($urandom(9));
    doReset(1'h0);
    look(32'h10, 32'h10);
    bus(`CMPC_OFF_MODE, 1'h0, 32'h0, 32'h1);
    // Debug enable needed for the erase and memory access paths
    bus(`CMPC_OFF_CTRL, 1'h1, 32'h1, 32'h0);
    secured <= 1'h1;
    @(posedge core_clk);
    look(32'h3, 32'h01800003);
    secured <= 1'h0;
    dbg(2'h3);
    bus(`CMPC_OFF_MODE, 1'h1, 32'h1, 32'h0);
    bus(`CMPC_OFF_MODE, 1'h0, 32'h1, 32'h1);
    doReset(1'h1);
    bus(`CMPC_OFF_MODE, 1'h1, 32'h0, 32'h0);
    bus(`CMPC_OFF_MODE, 1'h0, 32'h1, 32'h1);
    bus(`CMPC_OFF_CTRL, 1'h0, 32'h0, 32'hF);
    bus(8'h0C, 1'h1, 32'($urandom), 32'h0);
    bus(8'h0C, 1'h0, 32'h0, 32'hFFFFFFFF);
    look(32'h000FFF60, 32'h007FFFFF);
    bus(`CMPC_OFF_CTRL, 1'h1, {28'($urandom), 4'h5}, 32'h0);
    bus(`CMPC_OFF_CTRL, 1'h0, 32'h5, 32'hF);
    look(32'h00800000, 32'h01800000);
    dbg(2'h2);
    look(32'h18, 32'h18);
    dbg(2'h1);
    look(32'h0, 32'h18);
    intPend <= 1'h1;
    for (int k = 0; k < 3; k++)
    begin
      pulse(1'h0);
      waitSt(PS_WAIT);
      repeat ($urandom_range(8, 1)) @(posedge core_clk);
      look(32'h001F7F60, 32'h007FFFFF);
      setWake(wSrc[k], 1'h1);
      waitSt(PS_RUN);
      setWake(wSrc[k], 1'h0);
      repeat (4) @(posedge core_clk);
    end
    for (int k = 1; k < 4; k++)
    begin
      {ccrU, ccrS} <= 2'(k);
      @(posedge core_clk);
      pulse(1'h1);
      repeat (5) @(posedge core_clk);
      look(32'h0, 32'h00700000);
    end
    {ccrU, ccrS} <= 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      bus(`CMPC_OFF_CTRL, 1'h1, cV[k], 32'h0);
      nvmBusy <= 1'(k == 0);
      pulse(1'h1);
      repeat (4) @(posedge core_clk);
      if (k == 0)
        look(32'h0, 32'h00700000);
      nvmBusy <= 1'h0;
      waitSt(k == 1 ? PS_PSTOP : PS_STOP);
      repeat (2) @(posedge core_clk);
      look(sE[k], sM[k]);
      setWake(sSrc[k], 1'h1);
      waitSt(PS_WAKE);
      waitSt(PS_RUN);
      setWake(sSrc[k], 1'h0);
      repeat (4) @(posedge core_clk);
      look(32'h000FFF60, 32'h007FFFFF);
    end
    complete_run();
  end
endmodule
